// file: logic/map_port_if.sv
// port between the request handler and its register store
`timescale 1ns/10ps
`default_nettype none
interface map_port_if;
    logic                            wr_en;
    logic [regmap_pkg::RAM_AW-1:0]   wr_addr;
    logic [15:0]                     wr_data;
    logic [regmap_pkg::RAM_AW-1:0]   rd_addr;
    logic [15:0]                     rd_data;
    modport ctl   (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: logic/map_store.sv
// storage for the writable map words, registered read
`timescale 1ns/10ps
`default_nettype none
module map_store (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // access port
    map_port_if.store       mp
);
    logic [15:0] word_reg  [regmap_pkg::RAM_DEPTH];
    logic [15:0] word_next [regmap_pkg::RAM_DEPTH];
    logic [15:0] rd_reg;
    logic [15:0] rd_next;

    // one word per location, cleared at reset
    for (genvar i = 0; i < regmap_pkg::RAM_DEPTH; i++) begin : g_word
        always_comb begin
            word_next[i] = word_reg[i];
            if (mp.wr_en && mp.wr_addr == regmap_pkg::RAM_AW'(i)) begin
                word_next[i] = mp.wr_data;
            end
        end
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                word_reg[i] <= 16'h0000;
            end else begin
                word_reg[i] <= word_next[i];
            end
        end
    end

    // read data one cycle after the address
    always_comb rd_next = word_reg[mp.rd_addr];
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_reg <= 16'h0000;
        end else begin
            rd_reg <= rd_next;
        end
    end
    assign mp.rd_data = rd_reg;
endmodule
`default_nettype wire

// file: logic/regmap_pkg.sv
// constants and types shared by the request handler and its register store
`default_nettype none
package regmap_pkg;
    // bus address = register number minus one
    localparam logic [15:0] REG_NUM_FIRST = 16'h9C41;
    localparam logic [15:0] NUM_TO_ADDR   = 16'h0001;
    localparam logic [15:0] MAP_BASE      = REG_NUM_FIRST - NUM_TO_ADDR;
    // map layout in word indexes from MAP_BASE
    localparam logic [15:0] MAP_SIZE      = 16'h0078;
    localparam logic [15:0] DATA_IDX      = 16'h0004;
    localparam logic [15:0] END_IDX       = 16'h0076;
    localparam logic [15:0] MODEL_LEN     = 16'h0002;
    localparam logic [15:0] MARK_HI       = 16'h5375;
    localparam logic [15:0] MARK_LO       = 16'h6E53;
    localparam logic [15:0] END_ID        = 16'hFFFF;
    localparam logic [15:0] END_LEN       = 16'h0000;
    localparam int          MODEL_CNT     = 29;
    localparam logic [15:0] MODEL_ID [MODEL_CNT] = '{
        16'h0001, 16'h0011, 16'h0067, 16'h0078, 16'h0079, 16'h007A, 16'h007B, 16'h007E,
        16'h0081, 16'h0082, 16'h0084, 16'h0086, 16'h0087, 16'h0088, 16'h008B, 16'h008C,
        16'h008F, 16'h0090, 16'h0091, 16'hFD20, 16'hFB2C, 16'hFB2D, 16'hFB2E, 16'hFB2F,
        16'hFB30, 16'hFB31, 16'hFB32, 16'hFB33, 16'hFB34};
    // function codes, exception flag and codes
    localparam logic [7:0]  FC_READ       = 8'h03;
    localparam logic [7:0]  FC_PRESET     = 8'h06;
    localparam logic [7:0]  FC_MULTI      = 8'h10;
    localparam logic [7:0]  EXC_FLAG      = 8'h80;
    localparam logic [7:0]  EX_NONE       = 8'h00;
    localparam logic [7:0]  EX_FUNC       = 8'h01;
    localparam logic [7:0]  EX_ADDR       = 8'h02;
    localparam logic [7:0]  EX_VALUE      = 8'h03;
    localparam logic [7:0]  BCAST         = 8'h00;
    localparam logic [15:0] MAX_WR_QTY    = 16'h007B;
    localparam logic [15:0] MAX_RD_QTY    = 16'h007D;
    // request byte positions and response lengths
    localparam logic [7:0]  POS_SLAVE     = 8'h00;
    localparam logic [7:0]  POS_FC        = 8'h01;
    localparam logic [7:0]  POS_AHI       = 8'h02;
    localparam logic [7:0]  POS_ALO       = 8'h03;
    localparam logic [7:0]  POS_QHI       = 8'h04;
    localparam logic [7:0]  POS_QLO       = 8'h05;
    localparam logic [7:0]  POS_BC        = 8'h06;
    localparam logic [7:0]  POS_DATA      = 8'h07;
    localparam logic [7:0]  MIN_LAST      = 8'h05;
    localparam logic [7:0]  ECHO_LEN      = 8'h06;
    localparam logic [7:0]  EXC_LEN       = 8'h03;
    localparam logic [7:0]  RD_HDR_LEN    = 8'h03;
    // check value
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;
    localparam logic [15:0] CRC_POLY      = 16'hA001;
    // register store
    localparam int          RAM_AW        = 6;
    localparam int          RAM_DEPTH     = 64;
    typedef enum logic [1:0] {RESP_ECHO, RESP_EXC, RESP_READ} resp_kind_t;
endpackage
`default_nettype wire

// file: logic/write_handler.sv
// register request handler: preset, multi-write and read with replies
// Summary of operation
// - multi-write quantity 1..123, else value exception
// - two bytes per word, count twice quantity
// - multi-write reply: address, function, start, quantity
// - bus address is register number minus one
// - operating-locked writes dropped while converter on
// - map opens common model, closes end model
// - map lists the standard and extension models
// - write only writable words, read readable ones
// - preset echoed only after value stored; a preset to a locked word while converter on is echoed though not stored
// - exception reply sets function code top bit
// - codes 01 function, 02 address, 03 value
// - check value closes frame, low byte first
`timescale 1ns/10ps
`default_nettype none
module write_handler (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // unit identity and run state
    input  wire logic [7:0] own_addr,
    input  wire logic       conv_on,
    // request bytes, check value already stripped
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    input  wire logic       rx_last,
    // response bytes
    output logic [7:0]      tx_data,
    output logic            tx_valid,
    output logic            tx_last,
    input  wire logic       tx_ready,
    // handler state
    output logic            busy
);
    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_FETCH, ST_LOAD, ST_WAIT} state_t;

    state_t                 state_reg, state_next;
    regmap_pkg::resp_kind_t kind_reg, kind_next;
    logic [7:0]  rx_cnt_reg, rx_cnt_next, slave_reg, slave_next, fc_reg, fc_next;
    logic [7:0]  bc_reg, bc_next, hold_reg, hold_next, code_reg, code_next;
    logic [15:0] addr_reg, addr_next, qty_reg, qty_next, crc_reg, crc_next;
    logic [7:0]  tx_idx_reg, tx_idx_next, tx_data_reg, tx_data_next;
    logic        tx_valid_reg, tx_valid_next, tx_last_reg, tx_last_next;
    logic        busy_reg, busy_next;
    logic        rx_take, addressed;
    logic [7:0]  exc_code, dpos, body_len, rel, tx_byte;
    logic [15:0] idx, widx, tidx, word;

    map_port_if mp ();
    map_store map_store_i (.ref_clk(ref_clk), .resetn(resetn), .mp(mp.store));

    function automatic logic [15:0] map_index(input logic [15:0] a);
        return a - regmap_pkg::MAP_BASE;
    endfunction
    function automatic logic in_map(input logic [15:0] a);
        return (a >= regmap_pkg::MAP_BASE) && (map_index(a) < regmap_pkg::MAP_SIZE);
    endfunction
    // writable words are the two data words of each model block
    function automatic logic is_writable(input logic [15:0] a);
        logic [15:0] i;
        i = map_index(a);
        return in_map(a) && i >= regmap_pkg::DATA_IDX && i < regmap_pkg::END_IDX && !i[1];
    endfunction
    function automatic logic [regmap_pkg::RAM_AW-1:0] ram_addr(input logic [15:0] i);
        logic [15:0] d;
        d = i - regmap_pkg::DATA_IDX;
        // model k keeps its two data words at store words 2k and 2k+1
        return {d[6:2], d[0]};
    endfunction
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ regmap_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
    // map contents: marker, model headers, stored words, end model
    function automatic logic [15:0] word_at(input logic [15:0] i, input logic [15:0] ram);
        logic [15:0] r;
        r = i - 16'h0002;
        if (i == 16'h0000) return regmap_pkg::MARK_HI;
        if (i == 16'h0001) return regmap_pkg::MARK_LO;
        if (i == regmap_pkg::END_IDX) return regmap_pkg::END_ID;
        if (i > regmap_pkg::END_IDX) return regmap_pkg::END_LEN;
        if (r[1]) return ram;
        return r[0] ? regmap_pkg::MODEL_LEN : regmap_pkg::MODEL_ID[r[6:2]];
    endfunction

    // request checks
    always_comb begin
        addressed = (slave_reg == own_addr) || (slave_reg == regmap_pkg::BCAST);
        idx       = map_index(addr_reg);
        exc_code  = regmap_pkg::EX_NONE;
        case (fc_reg)
            regmap_pkg::FC_READ: begin
                if (qty_reg == 16'h0000 || qty_reg > regmap_pkg::MAX_RD_QTY) begin
                    exc_code = regmap_pkg::EX_VALUE;
                end else if (!in_map(addr_reg) || idx + qty_reg > regmap_pkg::MAP_SIZE) begin
                    exc_code = regmap_pkg::EX_ADDR;
                end
            end
            regmap_pkg::FC_PRESET: begin
                if (!is_writable(addr_reg)) exc_code = regmap_pkg::EX_ADDR;
            end
            regmap_pkg::FC_MULTI: begin
                if (qty_reg == 16'h0000 || qty_reg > regmap_pkg::MAX_WR_QTY ||
                    {8'h00, bc_reg} != {qty_reg[14:0], 1'b0}) begin
                    exc_code = regmap_pkg::EX_VALUE;
                end else if (!is_writable(addr_reg) ||
                             !(qty_reg == 16'h0001 || (qty_reg == 16'h0002 && !idx[0]))) begin
                    exc_code = regmap_pkg::EX_ADDR;
                end
            end
            default: exc_code = regmap_pkg::EX_FUNC;
        endcase
    end

    // request byte capture
    always_comb begin
        rx_take     = rx_valid && state_reg == ST_IDLE;
        slave_next  = slave_reg;
        fc_next     = fc_reg;
        addr_next   = addr_reg;
        qty_next    = qty_reg;
        bc_next     = bc_reg;
        hold_next   = hold_reg;
        rx_cnt_next = rx_cnt_reg;
        if (rx_take) begin
            case (rx_cnt_reg)
                regmap_pkg::POS_SLAVE: slave_next = rx_data;
                regmap_pkg::POS_FC:    fc_next = rx_data;
                regmap_pkg::POS_AHI:   addr_next[15:8] = rx_data;
                regmap_pkg::POS_ALO:   addr_next[7:0] = rx_data;
                regmap_pkg::POS_QHI:   qty_next[15:8] = rx_data;
                regmap_pkg::POS_QLO:   qty_next[7:0] = rx_data;
                regmap_pkg::POS_BC:    bc_next = rx_data;
                default:               hold_next = rx_data;
            endcase
            if (rx_last) begin
                rx_cnt_next = 8'h00;
            end else if (rx_cnt_reg != 8'hFF) begin
                rx_cnt_next = rx_cnt_reg + 8'h01;
            end
        end
    end

    // store writes: multi-write words as their low byte lands, preset at execute
    always_comb begin
        dpos       = rx_cnt_reg - regmap_pkg::POS_DATA;
        tidx       = idx + {9'h000, dpos[7:1]};
        mp.wr_en   = 1'b0;
        mp.wr_data = {hold_reg, rx_data};
        if (rx_take && rx_cnt_reg > regmap_pkg::POS_DATA && dpos[0] && addressed &&
            fc_reg == regmap_pkg::FC_MULTI && exc_code == regmap_pkg::EX_NONE &&
            {9'h000, dpos[7:1]} < qty_reg) begin
            mp.wr_en = !(conv_on && tidx[0]);
        end else if (state_reg == ST_EXEC && fc_reg == regmap_pkg::FC_PRESET && addressed &&
                     exc_code == regmap_pkg::EX_NONE) begin
            tidx       = idx;
            mp.wr_en   = !(conv_on && idx[0]);
            mp.wr_data = qty_reg;
        end
        mp.wr_addr = ram_addr(tidx);
    end

    // reply byte selection
    always_comb begin
        unique case (kind_reg)
            regmap_pkg::RESP_ECHO: body_len = regmap_pkg::ECHO_LEN;
            regmap_pkg::RESP_EXC:  body_len = regmap_pkg::EXC_LEN;
            regmap_pkg::RESP_READ: body_len = regmap_pkg::RD_HDR_LEN + {qty_reg[6:0], 1'b0};
        endcase
        rel        = tx_idx_reg - regmap_pkg::RD_HDR_LEN;
        widx       = idx + {9'h000, rel[7:1]};
        mp.rd_addr = ram_addr(widx);
        word       = word_at(widx, mp.rd_data);
        if (tx_idx_reg == body_len) begin
            tx_byte = crc_reg[7:0];
        end else if (tx_idx_reg == body_len + 8'h01) begin
            tx_byte = crc_reg[15:8];
        end else if (tx_idx_reg == 8'h00) begin
            tx_byte = slave_reg;
        end else if (tx_idx_reg == 8'h01) begin
            tx_byte = (kind_reg == regmap_pkg::RESP_EXC) ? (fc_reg | regmap_pkg::EXC_FLAG)
                                                        : fc_reg;
        end else if (kind_reg == regmap_pkg::RESP_EXC) begin
            tx_byte = code_reg;
        end else if (kind_reg == regmap_pkg::RESP_ECHO) begin
            unique case (tx_idx_reg[2:0])
                3'h2:    tx_byte = addr_reg[15:8];
                3'h3:    tx_byte = addr_reg[7:0];
                3'h4:    tx_byte = qty_reg[15:8];
                default: tx_byte = qty_reg[7:0];
            endcase
        end else if (tx_idx_reg == 8'h02) begin
            tx_byte = {qty_reg[6:0], 1'b0};
        end else begin
            tx_byte = rel[0] ? word[7:0] : word[15:8];
        end
    end

    // sequencing of execute and reply
    always_comb begin
        state_next    = state_reg;
        kind_next     = kind_reg;
        code_next     = code_reg;
        crc_next      = crc_reg;
        tx_idx_next   = tx_idx_reg;
        tx_data_next  = tx_data_reg;
        tx_valid_next = tx_valid_reg;
        tx_last_next  = tx_last_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (rx_take && rx_last && rx_cnt_reg >= regmap_pkg::MIN_LAST) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                code_next   = exc_code;
                tx_idx_next = 8'h00;
                crc_next    = regmap_pkg::CRC_INIT;
                if (exc_code != regmap_pkg::EX_NONE) begin
                    kind_next = regmap_pkg::RESP_EXC;
                end else if (fc_reg == regmap_pkg::FC_READ) begin
                    kind_next = regmap_pkg::RESP_READ;
                end else begin
                    kind_next = regmap_pkg::RESP_ECHO;
                end
                state_next = (addressed && slave_reg != regmap_pkg::BCAST) ? ST_FETCH : ST_IDLE;
            end
            ST_FETCH: state_next = ST_LOAD;
            ST_LOAD: begin
                tx_data_next  = tx_byte;
                tx_valid_next = 1'b1;
                tx_last_next  = tx_idx_reg == body_len + 8'h01;
                if (tx_idx_reg < body_len) crc_next = crc_step(crc_reg, tx_byte);
                tx_idx_next   = tx_idx_reg + 8'h01;
                state_next    = ST_WAIT;
            end
            ST_WAIT: begin
                if (tx_ready) begin
                    tx_valid_next = 1'b0;
                    tx_last_next  = 1'b0;
                    state_next    = tx_last_reg ? ST_IDLE : ST_FETCH;
                end
            end
        endcase
        busy_next = state_next != ST_IDLE;
    end

    // all handler registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= ST_IDLE;
            kind_reg     <= regmap_pkg::RESP_ECHO;
            rx_cnt_reg   <= 8'h00;
            slave_reg    <= 8'h00;
            fc_reg       <= 8'h00;
            bc_reg       <= 8'h00;
            hold_reg     <= 8'h00;
            code_reg     <= 8'h00;
            addr_reg     <= 16'h0000;
            qty_reg      <= 16'h0000;
            crc_reg      <= regmap_pkg::CRC_INIT;
            tx_idx_reg   <= 8'h00;
            tx_data_reg  <= 8'h00;
            tx_valid_reg <= 1'b0;
            tx_last_reg  <= 1'b0;
            busy_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            kind_reg     <= kind_next;
            rx_cnt_reg   <= rx_cnt_next;
            slave_reg    <= slave_next;
            fc_reg       <= fc_next;
            bc_reg       <= bc_next;
            hold_reg     <= hold_next;
            code_reg     <= code_next;
            addr_reg     <= addr_next;
            qty_reg      <= qty_next;
            crc_reg      <= crc_next;
            tx_idx_reg   <= tx_idx_next;
            tx_data_reg  <= tx_data_next;
            tx_valid_reg <= tx_valid_next;
            tx_last_reg  <= tx_last_next;
            busy_reg     <= busy_next;
        end
    end

    assign tx_data  = tx_data_reg;
    assign tx_valid = tx_valid_reg;
    assign tx_last  = tx_last_reg;
    assign busy     = busy_reg;

    // checks on the handler
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire logic [7:0] shown = tx_idx_reg - 8'h01;
    wr_qty_a: assert property (mp.wr_en && state_reg == ST_IDLE |->
        qty_reg >= 16'h0001 && qty_reg <= regmap_pkg::MAX_WR_QTY)
        else $error("multi-write quantity out of range");
    wr_bytes_a: assert property (mp.wr_en && state_reg == ST_IDLE |->
        {8'h00, bc_reg} == {qty_reg[14:0], 1'b0}) else $error("byte count not twice quantity");
    multi_len_a: assert property (tx_valid_reg && tx_last_reg &&
        fc_reg == regmap_pkg::FC_MULTI && kind_reg == regmap_pkg::RESP_ECHO |-> shown == 8'h07)
        else $error("multi reply length");
    wr_map_a: assert property (mp.wr_en |-> addr_reg >= 16'h9C40)
        else $error("write below map base");
    op_lock_a: assert property (mp.wr_en |-> !(conv_on && mp.wr_addr[0]))
        else $error("locked word written while on");
    wr_access_a: assert property (state_reg == ST_EXEC && !is_writable(addr_reg) |->
        !mp.wr_en) else $error("write to read-only word");
    echo_after_a: assert property (mp.wr_en && state_reg == ST_EXEC && slave_reg != 8'h00 |->
        !tx_valid_reg ##3 tx_valid_reg && tx_data_reg == slave_reg) else $error("echo timing");
    exc_flag_a: assert property (tx_valid_reg && kind_reg == regmap_pkg::RESP_EXC &&
        shown == 8'h01 |-> tx_data_reg == {1'b1, fc_reg[6:0]}) else $error("exception flag");
    exc_code_a: assert property (tx_valid_reg && kind_reg == regmap_pkg::RESP_EXC &&
        shown == 8'h02 |-> tx_data_reg inside {8'h01, 8'h02, 8'h03}) else $error("exception code");
    // first cycle of the last byte only: a stalled sink keeps it standing
    crc_high_a: assert property ($rose(tx_valid_reg) && tx_last_reg |->
        tx_data_reg == crc_reg[15:8] && $past(tx_data_reg, 3) == crc_reg[7:0])
        else $error("check value order");
endmodule
`default_nettype wire

// file: tb/modbus_master_model.sv
// behavioural master host: sends request bytes and takes reply bytes
`timescale 1ns/10ps
`default_nettype none
module modbus_master_model (
    // clock and unit state
    input  wire logic       ref_clk,
    input  wire logic       busy,
    // request stream to the unit
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            rx_last,
    // reply stream from the unit
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    typedef logic [7:0] bq_t[$];

    // lines idle at time zero
    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        rx_last  = 1'b0;
        tx_ready = 1'b0;
    end

    // one request, bytes back to back once the unit is idle
    task automatic send(input bq_t q);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
        foreach (q[i]) begin
            @(negedge ref_clk);
            rx_data  = q[i];
            rx_valid = 1'b1;
            rx_last  = (i == q.size() - 1);
        end
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_last  = 1'b0;
        rx_data  = ~rx_data; // released line must not show the stale byte
    endtask

    // take reply bytes until the last one, or give up after a quiet spell
    task automatic collect(input bit slow, input int limit, output bq_t q);
        int   idle;
        logic fin;
        q.delete();
        idle = 0;
        fin  = 1'b0;
        while (!fin && idle < limit) begin
            @(negedge ref_clk);
            idle++;
            if (tx_valid === 1'b1) begin
                if (slow) repeat (3) @(negedge ref_clk); // sink stalls a while
                q.push_back(tx_data);
                fin      = tx_last;
                tx_ready = 1'b1;
                @(negedge ref_clk);
                tx_ready = 1'b0;
                idle     = 0;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: tb/modbus_register_write_handler_tb.sv
// self-checking bench for the register request handler
`timescale 1ns/10ps
`default_nettype none
module modbus_register_write_handler_tb;
    typedef logic [7:0]  bq_t[$];
    typedef logic [15:0] wq_t[$];
    logic       ref_clk, resetn, conv_on, rx_valid, rx_last, tx_valid, tx_last, tx_ready, busy;
    logic [7:0] own_addr, rx_data, tx_data;
    int         bad_count, comparisons;
    bq_t        none;

    // 100 MHz clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // unit under test and master host
    write_handler write_handler_i (.ref_clk(ref_clk), .resetn(resetn), .own_addr(own_addr),
        .conv_on(conv_on), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .busy(busy));
    modbus_master_model modbus_master_model_i (.ref_clk(ref_clk), .busy(busy),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] expected, input string msg);
        comparisons++;
        if (seen !== expected) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, expected);
        end
    endtask

    // append check value, low byte first
    function automatic bq_t add_crc(bq_t q);
        logic [15:0] c;
        bq_t         r;
        c = 16'hFFFF;
        r = q;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        r.push_back(c[7:0]);
        r.push_back(c[15:8]);
        return r;
    endfunction

    // frame builders, fields high byte first
    function automatic bq_t wr1(logic [7:0] s, logic [15:0] a, logic [15:0] v);
        return {s, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]};
    endfunction
    function automatic bq_t rd(logic [15:0] a, logic [15:0] n);
        return {8'h0A, 8'h03, a[15:8], a[7:0], n[15:8], n[7:0]};
    endfunction
    function automatic bq_t mw(logic [15:0] a, logic [15:0] n, logic [7:0] bc, int nb);
        bq_t r;
        r = {8'h0A, 8'h10, a[15:8], a[7:0], n[15:8], n[7:0], bc};
        for (int i = 0; i < nb; i++) r.push_back(8'(i + 1));
        return r;
    endfunction
    function automatic bq_t rd_exp(wq_t w);
        bq_t r;
        r = {8'h0A, 8'h03, 8'(2 * w.size())};
        foreach (w[i]) begin
            r.push_back(w[i][15:8]);
            r.push_back(w[i][7:0]);
        end
        return add_crc(r);
    endfunction
    function automatic bq_t exc(logic [7:0] fc, logic [7:0] code);
        return add_crc({8'h0A, fc | 8'h80, code});
    endfunction

    // expected map after reset: marker, model headers, zero data, end model
    function automatic wq_t map_words();
        int  ids[20] = '{1, 17, 103, 120, 121, 122, 123, 126, 129, 130, 132, 134, 135, 136,
                         139, 140, 143, 144, 145, 64800};
        wq_t w;
        for (int i = 0; i < 120; i++) w.push_back(16'h0000);
        w[0] = 16'h5375;
        w[1] = 16'h6E53;
        for (int k = 0; k < 29; k++) begin
            w[2 + 4 * k] = (k < 20) ? 16'(ids[k]) : 16'(64300 + k - 20);
            w[3 + 4 * k] = 16'h0002;
        end
        w[118] = 16'hFFFF;
        return w;
    endfunction

    // one transfer, reply judged byte by byte
    task automatic run(input bq_t req, input bq_t exp, input bit slow, input string msg);
        bq_t got;
        modbus_master_model_i.send(req);
        modbus_master_model_i.collect(slow, 20, got);
        check(16'(got.size()), 16'(exp.size()), msg);
        foreach (exp[i]) if (i < got.size()) check({8'h00, got[i]}, {8'h00, exp[i]}, msg);
    endtask

    task automatic t_map();
        run(rd(16'(40001 - 1), 16'h0078), rd_exp(map_words()), 1'b0, "map");
        $display("map test done");
    endtask

    task automatic t_preset();
        bq_t req;
        req = wr1(8'h0A, 16'(40005 - 1), 16'h0001);
        run(req, add_crc(req), 1'b1, "preset echo");
        run(rd(16'h9C44, 16'h0001), rd_exp({16'h0001}), 1'b0, "preset store");
        $display("preset test done");
    endtask

    task automatic t_lock();
        bq_t req;
        conv_on = 1'b1;
        req = wr1(8'h0A, 16'h9C45, 16'h1234);
        run(req, add_crc(req), 1'b0, "locked echo");
        req = wr1(8'h0A, 16'h9C44, 16'h0055);
        run(req, add_crc(req), 1'b0, "free echo");
        run(rd(16'h9C44, 16'h0002), rd_exp({16'h0055, 16'h0000}), 1'b0, "locked drop");
        conv_on = 1'b0;
        req = wr1(8'h0A, 16'h9C45, 16'h1234);
        run(req, add_crc(req), 1'b0, "unlocked echo");
        run(rd(16'h9C45, 16'h0001), rd_exp({16'h1234}), 1'b0, "unlocked store");
        $display("lock test done");
    endtask

    task automatic t_addr();
        run(wr1(8'h00, 16'h9C4C, 16'h00AA), none, 1'b0, "broadcast");
        run(wr1(8'h0B, 16'h9C4D, 16'h00BB), none, 1'b0, "other unit");
        run(rd(16'h9C4C, 16'h0002), rd_exp({16'h00AA, 16'h0000}), 1'b0, "unit filter");
        $display("address test done");
    endtask

    task automatic t_multi();
        bq_t req;
        req = {mw(16'h9C48, 16'h0002, 8'h04, 0), 8'h17, 8'hD4, 8'h27, 8'h10};
        run(req, add_crc(req[0:5]), 1'b1, "multi reply");
        run(rd(16'h9C48, 16'h0002), rd_exp({16'h17D4, 16'h2710}), 1'b0, "multi store");
        run(mw(16'h9C48, 16'h007B, 8'hF6, 246), exc(8'h10, 8'h02), 1'b0, "qty 123");
        run(mw(16'h9C48, 16'h007C, 8'hF8, 248), exc(8'h10, 8'h03), 1'b0, "qty 124");
        run(mw(16'h9C48, 16'h0000, 8'h00, 0), exc(8'h10, 8'h03), 1'b0, "qty 0");
        run(mw(16'h9C48, 16'h0002, 8'h03, 3), exc(8'h10, 8'h03), 1'b0, "byte count");
        $display("multi test done");
    endtask

    task automatic t_exc();
        run({8'h0A, 8'h05, 8'h9C, 8'h44, 8'h00, 8'h01}, exc(8'h05, 8'h01), 0, "func");
        run(wr1(8'h0A, 16'h9C40, 16'h0001), exc(8'h06, 8'h02), 1'b0, "read-only");
        run(rd(16'h9C40, 16'h0000), exc(8'h03, 8'h03), 1'b0, "read qty 0");
        run(rd(16'h9CB8, 16'h0001), exc(8'h03, 8'h02), 1'b0, "read outside");
        $display("exception test done");
    endtask

    // counts and verdict, then end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // main sequence
    initial begin
        resetn = 1'b0;
        conv_on = 1'b0;
        own_addr = 8'h0A;
        bad_count = 0;
        comparisons = 0;
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        t_map();
        t_preset();
        t_lock();
        t_addr();
        t_multi();
        t_exc();
        stop_test();
    end

    // watchdog against a hang
    initial begin
        #200_000;
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
